// >>> src/opdec_pkg.sv
// Constants, types and field layouts for the operand field decoder.
package opdec_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Basic widths.
   typedef logic [15:0] iword_t;
   typedef logic [20:0] paddr_t;
   typedef logic [11:0] faddr_t;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] bank_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the bus.
   localparam logic [7:0] ADR_WACC = 8'h00;
   localparam logic [7:0] ADR_BANK = 8'h04;
   localparam logic [7:0] ADR_TPTR = 8'h08;
   localparam logic [7:0] ADR_TLAT = 8'h0C;
   localparam logic [7:0] ADR_FLAGS = 8'h10;
   localparam logic [7:0] ADR_IPTR0 = 8'h14;
   localparam logic [7:0] ADR_IPTR1 = 8'h18;
   localparam logic [7:0] ADR_IPTR2 = 8'h1C;
   localparam logic [7:0] ADR_IPTR3 = 8'h20;
   localparam logic [7:0] ADR_DEC = 8'h24;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam byte_t RST_WACC = 8'h00;
   localparam bank_t RST_BANK = 4'h0;
   localparam paddr_t RST_TPTR = 21'h000000;
   localparam byte_t RST_TLAT = 8'h00;
   localparam logic [4:0] RST_FLAGS = 5'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Fixed access region and field positions.
   localparam byte_t ACCESS_SPLIT = 8'h60;
   localparam bank_t ACCESS_LOW_BANK = 4'h0;
   localparam bank_t ACCESS_HIGH_BANK = 4'hF;
   localparam int F_DEST = 9;
   localparam int F_ACC = 8;
   localparam int F_FAST_CALL = 8;
   localparam int F_FAST_RET = 0;
   localparam int F_TBL_WR = 2;
   localparam int INDEX_PTR = 2;
   localparam logic [3:0] SECOND_NIBBLE = 4'hF;
   localparam paddr_t PC_STEP = 21'h000002;
   localparam int OSC_PER_CYCLE = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Opcode patterns and masks; masked-out bits are don't care.
   localparam iword_t P_MOVFF = 16'hC000;
   localparam iword_t M_MOVFF = 16'hF000;
   localparam iword_t P_LFSR = 16'hEE00;
   localparam iword_t M_LFSR = 16'hFFC0;
   localparam iword_t P_MOVSF = 16'hEB00;
   localparam iword_t P_MOVSS = 16'hEB80;
   localparam iword_t M_MOVS = 16'hFF80;
   localparam iword_t P_GOTO = 16'hEF00;
   localparam iword_t M_GOTO = 16'hFF00;
   localparam iword_t P_CALL = 16'hEC00;
   localparam iword_t M_CALL = 16'hFE00;
   localparam iword_t P_RET = 16'h0012;
   localparam iword_t M_RET = 16'hFFFE;
   localparam iword_t P_BRA = 16'hD000;
   localparam iword_t M_BRA = 16'hF800;
   localparam iword_t P_BCOND = 16'hE000;
   localparam iword_t M_BCOND = 16'hF800;
   localparam iword_t P_TBL = 16'h0008;
   localparam iword_t M_TBL = 16'hFFF8;
   localparam iword_t P_LIT = 16'h0800;
   localparam iword_t M_LIT = 16'hF800;
   localparam iword_t P_BIT = 16'h8000;
   localparam iword_t M_BIT = 16'hC000;
   localparam iword_t P_BTG = 16'h7000;
   localparam iword_t M_BTG = 16'hF000;

   ////////////////////////////////////////////////////////////////////////////////
   // Enumerations.
   typedef enum logic [1:0] {
      TM_NONE = 2'h0, TM_POST_INC = 2'h1, TM_POST_DEC = 2'h2, TM_PRE_INC = 2'h3
   } table_pointer_mode_t;
   typedef enum logic [3:0] {
      K_NOP = 4'h0, K_BYTE = 4'h1, K_BIT = 4'h2, K_LIT = 4'h3, K_MOVE = 4'h4,
      K_PTRLOAD = 4'h5, K_REL = 4'h6, K_ABS = 4'h7, K_CALL = 4'h8, K_RET = 4'h9,
      K_TABLE = 4'hA, K_IDX = 4'hB, K_CTRL = 4'hC
   } kind_t;
   typedef enum logic [3:0] {Q1 = 4'h1, Q2 = 4'h2, Q3 = 4'h4, Q4 = 4'h8} phase_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers.
   typedef struct packed {
      logic neg;
      logic overflow_flag;
      logic zero;
      logic digit_carry_flag;
      logic carry;
   } flags_t;
   typedef struct packed {
      kind_t kind;
      faddr_t file_addr;
      faddr_t dst_addr;
      logic dest_file;
      logic acc_bank;
      byte_t bit_mask;
      logic [19:0] lit;
      logic [1:0] ptr_sel;
      paddr_t target;
      logic fast;
      table_pointer_mode_t table_pointer_mode;
      logic [6:0] indexed_source_offset;
      logic [6:0] indexed_destination_offset;
   } dec_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic stb;
      logic we;
      paddr_t addr;
      byte_t wdata;
   } tbl_req_t;
   typedef struct packed {
      byte_t wacc;
      flags_t flags;
      bank_t bank;
   } shadow_t;

endpackage

// >>> src/shadow_store.sv
`timescale 1ns/1ps
// Shadow copies of the core registers used by fast call and return.
module shadow_store
(
   // Clock and reset.
   input logic clk_i,
   input logic rst_i,
   // Save request and values.
   input logic save_i,
   input opdec_pkg::shadow_t data_i,
   output opdec_pkg::shadow_t data_o
);
   import opdec_pkg::*;

   typedef struct packed {
      shadow_t copy;
   } sstate_t;

   sstate_t s_q;
   sstate_t s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // capture on fast call.
   always_comb
   begin
      s_d = s_q;
      if (save_i)
      begin
         s_d.copy = data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign data_o = s_q.copy;

   ////////////////////////////////////////////////////////////////////////////////
   AST_SHADOW_SAVE: assert property (@(posedge clk_i) disable iff (rst_i)
      save_i |=> data_o == $past(data_i))
      else $error("Shadow copy not captured on fast call.");

endmodule

// >>> src/operand_field_decoder.sv
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// Operand field decoder with core registers and a Wishbone register slave.
// What this block does
// - Access bit 0 addresses the fixed access region, ignoring the bank register.
// - Access bit 1 takes the operand bank from the bank register.
// - Bit index field picks one bit, 0 to 7, of the 8-bit register.
// - Destination bit 0 sends results to the accumulator, 1 to the register.
// - Short file field is an 8-bit address or a 2-bit pointer selector.
// - Memory move carries full 12-bit source and destination addresses, no banking.
// - Literals decode as 8, 12 or 20 bits by instruction.
// - Branch field is signed displacement for relative, absolute for call and goto.
// - Fast bit 1 saves shadows on call and restores them on return.
// - Table accesses keep, post-increment, post-decrement or pre-increment the pointer.
// - The 21-bit table pointer addresses program memory through the 8-bit latch.
// - Indexed source uses a 7-bit offset added to the indirect pointer.
// - Indexed destination uses its own 7-bit offset on the indirect pointer.
// - Don't-care instruction bits never change decoding; tools emit them as 0.
// - Five status flags are kept: carry, digit carry, zero, overflow, negative.
// - A lone second word, leading four ones, decodes as no operation.
// - One instruction cycle spans four clock phases; one word taken per cycle.
module operand_field_decoder
(
   // Clock and reset.
   input logic clk_i,
   input logic rst_i,
   // Instruction fetch path.
   input logic iw_valid_i,
   input opdec_pkg::iword_t iw_i,
   input opdec_pkg::paddr_t pc_i,
   output logic iw_ready_o,
   // Datapath results.
   input logic result_valid_i,
   input opdec_pkg::byte_t result_i,
   input logic flags_we_i,
   input opdec_pkg::flags_t flags_i,
   // Table transfers.
   input logic tbl_rvalid_i,
   input opdec_pkg::byte_t tbl_rdata_i,
   output opdec_pkg::tbl_req_t tbl_o,
   // Decoded operands and core registers.
   output opdec_pkg::dec_t dec_o,
   output logic dec_valid_o,
   output opdec_pkg::byte_t working_accumulator_o,
   output opdec_pkg::bank_t bank_select_reg_o,
   output opdec_pkg::paddr_t table_pointer_o,
   output opdec_pkg::byte_t table_latch_o,
   output opdec_pkg::flags_t flags_o,
   // Wishbone slave.
   input opdec_pkg::wb_req_t wb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import opdec_pkg::*;
   typedef struct packed {
      phase_t phase;
      logic rdy;
      logic pend;
      iword_t first;
      byte_t wacc;
      bank_t bank;
      paddr_t tptr;
      byte_t tlat;
      flags_t flags;
      faddr_t [3:0] iptr;
      dec_t dec;
      logic dec_valid;
      tbl_req_t tbl;
      logic [31:0] wb_dat;
      logic ack;
   } state_t;
   state_t s_q;
   state_t s_d;
   shadow_t shadow;
   logic save;
   logic take;
   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.
   function automatic logic match(iword_t w, iword_t p, iword_t m);
      return (w & m) == p;
   endfunction
   function automatic faddr_t bank_addr(logic acc, byte_t f, bank_t bank);
      faddr_t r;
      r = {bank, f};
      if (!acc)
         r = (f < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f} : {ACCESS_HIGH_BANK, f};
      return r;
   endfunction
   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] dat, logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = dat[i*8 +: 8];
      return r;
   endfunction
   shadow_store u_shadow
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .save_i(save),
      .data_i({s_q.wacc, s_q.flags, s_q.bank}),
      .data_o(shadow)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb
   begin
      logic [31:0] rd;
      logic [31:0] wv;
      logic [7:0] ioff;
      dec_t dw;
      s_d = s_q;
      rd = '0;
      wv = '0;
      ioff = wb_i.adr - ADR_IPTR0;
      dw = '0;
      save = 1'b0;
      take = s_q.rdy && iw_valid_i;
      case (s_q.phase)
         Q1: s_d.phase = Q2;
         Q2: s_d.phase = Q3;
         Q3: s_d.phase = Q4;
         Q4: s_d.phase = Q1;
         default: s_d.phase = Q1;
      endcase
      s_d.rdy = (s_d.phase == Q1);
      s_d.dec_valid = 1'b0;
      s_d.tbl.stb = 1'b0;
      s_d.ack = 1'b0;
      // Register bus: one-cycle answer, unmapped reads as zero.
      case (wb_i.adr)
         ADR_WACC: rd = {24'h000000, s_q.wacc};
         ADR_BANK: rd = {28'h0000000, s_q.bank};
         ADR_TPTR: rd = {11'h000, s_q.tptr};
         ADR_TLAT: rd = {24'h000000, s_q.tlat};
         ADR_FLAGS: rd = {27'h0000000, s_q.flags};
         ADR_IPTR0, ADR_IPTR1, ADR_IPTR2, ADR_IPTR3: rd = {20'h00000, s_q.iptr[ioff[3:2]]};
         ADR_DEC: rd = {4'h0, s_q.dec.kind, s_q.dec.bit_mask, s_q.dec.file_addr, 3'h0, s_q.pend};
         default: rd = '0;
      endcase
      wv = merge(rd, wb_i.dat, wb_i.sel);
      if (wb_i.cyc && wb_i.stb && !s_q.ack)
      begin
         s_d.ack = 1'b1;
         s_d.wb_dat = wb_i.we ? '0 : rd;
         if (wb_i.we)
            case (wb_i.adr)
               ADR_WACC: s_d.wacc = wv[7:0];
               ADR_BANK: s_d.bank = wv[3:0];
               ADR_TPTR: s_d.tptr = wv[20:0];
               ADR_TLAT: s_d.tlat = wv[7:0];
               ADR_FLAGS: s_d.flags = wv[4:0];
               ADR_IPTR0, ADR_IPTR1, ADR_IPTR2, ADR_IPTR3: s_d.iptr[ioff[3:2]] = wv[11:0];
               default: s_d.wb_dat = '0;
            endcase
      end
      // Instruction word decode.
      if (take)
      begin
         s_d.dec_valid = 1'b1;
         s_d.pend = 1'b0;
         if (s_q.pend && iw_i[15:12] == SECOND_NIBBLE)
         begin
            if (match(s_q.first, P_MOVFF, M_MOVFF))
            begin
               dw.kind = K_MOVE;
               dw.file_addr = s_q.first[11:0];
               dw.dst_addr = iw_i[11:0];
            end
            else if (match(s_q.first, P_LFSR, M_LFSR))
            begin
               dw.kind = K_PTRLOAD;
               dw.ptr_sel = s_q.first[5:4];
               dw.lit = {8'h00, s_q.first[3:0], iw_i[7:0]};
               s_d.iptr[dw.ptr_sel] = dw.lit[11:0];
            end
            else if (match(s_q.first, P_MOVSF, M_MOVS))
            begin
               dw.kind = K_IDX;
               dw.indexed_source_offset = s_q.first[6:0];
               dw.file_addr = s_q.iptr[INDEX_PTR] + {5'h00, s_q.first[6:0]};
               dw.dst_addr = iw_i[11:0];
            end
            else if (match(s_q.first, P_MOVSS, M_MOVS))
            begin
               dw.kind = K_IDX;
               dw.indexed_source_offset = s_q.first[6:0];
               dw.indexed_destination_offset = iw_i[6:0];
               dw.file_addr = s_q.iptr[INDEX_PTR] + {5'h00, s_q.first[6:0]};
               dw.dst_addr = s_q.iptr[INDEX_PTR] + {5'h00, iw_i[6:0]};
            end
            else
            begin
               dw.kind = match(s_q.first, P_CALL, M_CALL) ? K_CALL : K_ABS;
               dw.lit = {iw_i[11:0], s_q.first[7:0]};
               dw.target = {dw.lit, 1'b0};
               dw.fast = (dw.kind == K_CALL) && s_q.first[F_FAST_CALL];
               save = dw.fast;
            end
         end
         else if (iw_i[15:12] == SECOND_NIBBLE)
            dw.kind = K_NOP;
         else if (match(iw_i, P_MOVFF, M_MOVFF) || match(iw_i, P_LFSR, M_LFSR)
                  || match(iw_i, P_MOVSF, M_MOVS) || match(iw_i, P_MOVSS, M_MOVS)
                  || match(iw_i, P_GOTO, M_GOTO) || match(iw_i, P_CALL, M_CALL))
         begin
            s_d.pend = 1'b1;
            s_d.first = iw_i;
            s_d.dec_valid = 1'b0;
         end
         else if (match(iw_i, P_BIT, M_BIT) || match(iw_i, P_BTG, M_BTG))
         begin
            dw.kind = K_BIT;
            dw.acc_bank = iw_i[F_ACC];
            dw.file_addr = bank_addr(iw_i[F_ACC], iw_i[7:0], s_q.bank);
            dw.bit_mask = 8'h01 << iw_i[11:9];
         end
         else if (match(iw_i, P_BRA, M_BRA))
         begin
            dw.kind = K_REL;
            dw.target = pc_i + PC_STEP + {{9{iw_i[10]}}, iw_i[10:0], 1'b0};
         end
         else if (match(iw_i, P_BCOND, M_BCOND))
         begin
            dw.kind = K_REL;
            dw.target = pc_i + PC_STEP + {{12{iw_i[7]}}, iw_i[7:0], 1'b0};
         end
         else if (match(iw_i, P_LIT, M_LIT))
         begin
            dw.kind = K_LIT;
            dw.lit = {12'h000, iw_i[7:0]};
         end
         else if (match(iw_i, P_RET, M_RET))
         begin
            dw.kind = K_RET;
            dw.fast = iw_i[F_FAST_RET];
            if (dw.fast)
            begin
               s_d.wacc = shadow.wacc;
               s_d.flags = shadow.flags;
               s_d.bank = shadow.bank;
            end
         end
         else if (match(iw_i, P_TBL, M_TBL))
         begin
            dw.kind = K_TABLE;
            dw.table_pointer_mode = table_pointer_mode_t'(iw_i[1:0]);
            s_d.tbl.stb = 1'b1;
            s_d.tbl.we = iw_i[F_TBL_WR];
            s_d.tbl.wdata = s_q.tlat;
            s_d.tbl.addr = s_q.tptr;
            case (dw.table_pointer_mode)
               TM_POST_INC: s_d.tptr = s_q.tptr + 21'h000001;
               TM_POST_DEC: s_d.tptr = s_q.tptr - 21'h000001;
               TM_PRE_INC:
               begin
                  s_d.tptr = s_q.tptr + 21'h000001;
                  s_d.tbl.addr = s_d.tptr;
               end
               default: s_d.tptr = s_q.tptr;
            endcase
         end
         else if (iw_i[15:12] != 4'h0 || (iw_i[11] == 1'b0 && iw_i[10:9] != 2'h0))
         begin
            dw.kind = K_BYTE;
            dw.dest_file = iw_i[F_DEST];
            dw.acc_bank = iw_i[F_ACC];
            dw.file_addr = bank_addr(iw_i[F_ACC], iw_i[7:0], s_q.bank);
         end
         else
            dw.kind = K_CTRL;
         s_d.dec = dw;
      end
      if (tbl_rvalid_i)
         s_d.tlat = tbl_rdata_i;
      if (result_valid_i && !s_q.dec.dest_file)
         s_d.wacc = result_i;
      if (flags_we_i)
         s_d.flags = flags_i;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.phase <= Q1;
         s_q.rdy <= 1'b1;
         s_q.wacc <= RST_WACC;
         s_q.bank <= RST_BANK;
         s_q.tptr <= RST_TPTR;
         s_q.tlat <= RST_TLAT;
         s_q.flags <= RST_FLAGS;
      end
      else
         s_q <= s_d;
   end
   assign iw_ready_o = s_q.rdy;
   assign tbl_o = s_q.tbl;
   assign dec_o = s_q.dec;
   assign dec_valid_o = s_q.dec_valid;
   assign working_accumulator_o = s_q.wacc;
   assign bank_select_reg_o = s_q.bank;
   assign table_pointer_o = s_q.tptr;
   assign table_latch_o = s_q.tlat;
   assign flags_o = s_q.flags;
   assign wb_dat_o = s_q.wb_dat;
   assign wb_ack_o = s_q.ack;
   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_ACCESS_REGION: assert property (
      dec_valid_o && dec_o.kind == K_BYTE && !dec_o.acc_bank |->
      dec_o.file_addr[11:8] == ACCESS_LOW_BANK || dec_o.file_addr[11:8] == ACCESS_HIGH_BANK)
      else $error("Access-region address escaped the fixed region.");
   AST_BANKED: assert property (
      dec_valid_o && dec_o.kind == K_BYTE && dec_o.acc_bank |->
      dec_o.file_addr[11:8] == $past(bank_select_reg_o))
      else $error("Banked address does not use the bank register.");
   AST_BIT_ONEHOT: assert property (
      dec_valid_o && dec_o.kind == K_BIT |-> $onehot(dec_o.bit_mask))
      else $error("Bit select is not a single bit.");
   AST_RESULT_ROUTE: assert property (
      result_valid_i && !dec_o.dest_file && !flags_we_i |=> working_accumulator_o == $past(result_i))
      else $error("Result not routed to the accumulator.");
   AST_POST_INC: assert property (
      take && match(iw_i, P_TBL, M_TBL) && !s_q.pend && iw_i[1:0] == TM_POST_INC |=>
      table_pointer_o == $past(table_pointer_o) + 21'h000001 && tbl_o.addr == $past(table_pointer_o))
      else $error("Post-increment table access wrong.");
   AST_LONE_SECOND: assert property (
      take && !s_q.pend && iw_i[15:12] == SECOND_NIBBLE |=> dec_valid_o && dec_o.kind == K_NOP)
      else $error("Lone second word not decoded as no operation.");
   AST_CYCLE_SPACING: assert property (
      dec_valid_o |=> !dec_valid_o [*3])
      else $error("Decodes closer than one instruction cycle.");
   AST_INDEXED_SRC: assert property (
      dec_valid_o && dec_o.kind == K_IDX |->
      dec_o.file_addr == $past(s_q.iptr[INDEX_PTR]) + {5'h00, dec_o.indexed_source_offset})
      else $error("Indexed source address wrong.");
   AST_WB_ACK: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("Bus answer held longer than one cycle.");
   COV_TABLE: cover property (dec_valid_o && dec_o.kind == K_TABLE);
   COV_FAST_RET: cover property (dec_valid_o && dec_o.kind == K_RET && dec_o.fast);
   COV_MOVE: cover property (dec_valid_o && dec_o.kind == K_MOVE);
endmodule

// >>> verif/fetch_model.sv
// Instruction fetch path model that offers words to the decoder.
`timescale 1ns/1ps
module fetch_model
(
   // Clock and handshake.
   input wire logic clk_i,
   input wire logic iw_ready_i,
   // Offered word.
   output logic iw_valid_o = 1'b0,
   output opdec_pkg::iword_t iw_o = 16'h0000,
   output opdec_pkg::paddr_t pc_o = 21'h000000
);
   import opdec_pkg::*;
   // Holds a word until it is taken, then shows the inverse value.
   task automatic send(input iword_t w, input paddr_t p);
      @(posedge clk_i);
      iw_valid_o <= 1'b1;
      iw_o <= w;
      pc_o <= p;
      do
      begin
         @(posedge clk_i);
      end
      while (iw_ready_i !== 1'b1);
      iw_valid_o <= 1'b0;
      iw_o <= ~w;
      pc_o <= ~p;
   endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the operand field decoder.
`timescale 1ns/1ps
module tb_top;
   import opdec_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic vld, rdy, dv, ack;
   logic rv = 1'b0, fwe = 1'b0, trv = 1'b0;
   iword_t iw;
   paddr_t pc, tptr;
   byte_t res = 8'h00, trd = 8'h00, wacc, tlat;
   flags_t fl = 5'h00, flo;
   tbl_req_t tbl;
   dec_t dec;
   bank_t bank;
   wb_req_t wb = '0;
   logic [31:0] wdat, rd;
   int bad_count = 0, n_checks = 0, cyc = 0;
   always #50 clk_i = ~clk_i;
   fetch_model FM (.clk_i(clk_i), .iw_ready_i(rdy), .iw_valid_o(vld), .iw_o(iw), .pc_o(pc));
   operand_field_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .iw_valid_i(vld), .iw_i(iw),
      .pc_i(pc), .iw_ready_o(rdy), .result_valid_i(rv), .result_i(res), .flags_we_i(fwe),
      .flags_i(fl), .tbl_rvalid_i(trv), .tbl_rdata_i(trd), .tbl_o(tbl), .dec_o(dec),
      .dec_valid_o(dv), .working_accumulator_o(wacc), .bank_select_reg_o(bank),
      .table_pointer_o(tptr), .table_latch_o(tlat), .flags_o(flo), .wb_i(wb),
      .wb_dat_o(wdat), .wb_ack_o(ack));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %0t got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb <= '{1'b1, 1'b1, w, a, 4'hF, d};
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      rd = wdat;
      wb <= '0;
   endtask
   task automatic fetch(input iword_t w, input paddr_t p = 21'h000000);
      FM.send(w, p);
      @(negedge clk_i);
   endtask
   task automatic pls(input logic [2:0] k, input byte_t v);
      @(posedge clk_i);
      {trv, fwe, rv} <= k;
      res <= v;
      trd <= v;
      fl <= v[4:0];
      @(posedge clk_i);
      {trv, fwe, rv} <= 3'h0;
      @(negedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one word each four cycles.
   task automatic t_reset();
      int n;
      n = 0;
      repeat (8)
      begin
         @(negedge clk_i);
         n += (rdy === 1'b1);
      end
      chk(n, 2);
      bus(1'b0, ADR_TPTR, 32'h0);
      chk(rd, RST_TPTR);
      bus(1'b1, 8'hFC, 32'h55);
      bus(1'b0, 8'hFC, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_bank();
      logic [8:0] af [3];
      faddr_t ex [3];
      byte_t w;
      af = '{9'h033, 9'h080, 9'h133};
      ex = '{12'h033, 12'hF80, 12'h533};
      w = RST_WACC;
      bus(1'b1, ADR_BANK, 32'h5);
      chk(bank, 4'h5);
      for (int i = 0; i < 3; i++)
      begin
         fetch({6'h09, i[0], af[i]});
         chk(dec.kind, K_BYTE);
         chk(dec.file_addr, ex[i]);
         chk(dec.dest_file, i[0]);
         pls(3'h1, 8'hA0 + 8'(i));
         if (!i[0])
            w = 8'hA0 + 8'(i);
         chk(wacc, w);
      end
   endtask
   task automatic t_bit();
      for (int b = 0; b < 8; b++)
      begin
         fetch({4'h8, b[2:0], 9'h010});
         chk(dec.bit_mask, 8'h01 << b);
      end
   endtask
   task automatic t_move();
      fetch(16'hCFFF);
      chk(dv, 1'b0);
      fetch(16'hF000);
      chk(dec.kind, K_MOVE);
      chk({dec.file_addr, dec.dst_addr}, 24'hFFF000);
      fetch(16'hF123);
      chk({dv, dec.kind}, {1'b1, K_NOP});
   endtask
   task automatic t_lit();
      for (int s = 0; s < 4; s++)
      begin
         fetch({10'h3B8, s[1:0], 4'hA});
         fetch({8'hF0, 4'h5, s[3:0]});
         chk(dec.ptr_sel, s[1:0]);
         bus(1'b0, ADR_IPTR0 + 8'(4 * s), 32'h0);
         chk(rd, 32'hA50 + s);
      end
      fetch(16'h0E7F);
      chk(dec.lit, 20'h0007F);
   endtask
   task automatic t_branch();
      fetch(16'hD7FE, 21'h000100);
      chk(dec.target, 21'h0000FE);
      fetch(16'hEF34);
      fetch(16'hF012);
      chk(dec.kind, K_ABS);
      chk(dec.target, 21'h002468);
      chk(dec.lit, 20'h01234);
      fetch(16'hE0FF, 21'h000200);
      chk(dec.target, 21'h000200);
   endtask
   task automatic t_table();
      paddr_t p;
      p = 21'h00FFFF;
      bus(1'b1, ADR_TPTR, 32'h00FFFF);
      pls(3'h4, 8'h5A);
      chk(tlat, 8'h5A);
      for (int m = 0; m < 4; m++)
      begin
         fetch({14'h0002, m[1:0]});
         chk(tbl.stb, 1'b1);
         chk(tbl.addr, (m == 3) ? p + 21'h1 : p);
         p = (m == 2) ? p - 21'h1 : (m == 0) ? p : p + 21'h1;
         chk(tptr, p);
      end
      fetch(16'h000C);
      chk({tbl.we, tbl.wdata}, 9'h15A);
   endtask
   task automatic t_misc();
      pls(3'h2, 8'h15);
      chk(flo, 5'h15);
      bus(1'b1, ADR_WACC, 32'h11);
      fetch(16'hED12);
      fetch(16'hF000);
      chk(dec.fast, 1'b1);
      bus(1'b1, ADR_WACC, 32'h22);
      fetch(16'h0013);
      chk(wacc, 8'h11);
      bus(1'b1, ADR_WACC, 32'h33);
      fetch(16'h0012);
      chk(wacc, 8'h33);
      fetch(16'hEB7F);
      fetch(16'hF123);
      chk(dec.indexed_source_offset, 7'h7F);
      chk({dec.file_addr, dec.dst_addr}, 24'hAD1123);
      fetch(16'hEB81);
      fetch(16'hF05A);
      chk(dec.indexed_destination_offset, 7'h5A);
      chk({dec.file_addr, dec.dst_addr}, 24'hA53AAC);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         bad_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_bank();
      t_bit();
      t_move();
      t_lit();
      t_branch();
      t_table();
      t_misc();
      close_out();
   end
endmodule
